/* src/uart_addr_wake_break.sv */
// Async serial port with address detect, wake on edge and break transmit.
// Assumes single clk_in domain; receive_line is an asynchronous pin.
`timescale 1ns/1ns
`include "uart_awb_cfg.svh"

module uart_addr_wake_break (
    input  wire logic       clk_in,         // System clock 100 MHz
    input  wire logic       rst_in,         // Sync reset, active high
    input  wire logic [2:0] addr_in,        // Register index
    input  wire logic [7:0] wdata_in,       // Write data
    input  wire logic       wr_in,          // Write strobe
    input  wire logic       rd_in,          // Read strobe
    output logic      [7:0] rdata_out,      // Read data, cycle after strobe
    input  wire logic       receive_line,   // Serial input pin
    output logic            transmit_out,   // Serial output pin
    output logic            irq_out         // Receive interrupt request
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                 rdata;
        logic [2:0]                 rx_sync;
        logic                       rx_line;
        logic [7:0]                 rcsta;
        logic [7:0]                 txsta;
        logic                       wake_en;
        logic [7:0]                 div_hi;
        logic [7:0]                 div_lo;
        logic [2:0]                 irqc;
        logic [15:0]                brg_cnt;
        logic [3:0]                 rx_ovs;
        logic [3:0]                 tx_ovs;
        uart_awb_pkg::rx_state_e    rx_st;
        logic [3:0]                 rx_bit;
        logic [8:0]                 rx_sh;
        logic [8:0]                 fifo0;
        logic [8:0]                 fifo1;
        logic [1:0]                 fcnt;
        logic                       ferr0;
        logic                       ferr1;
        uart_awb_pkg::wake_state_e  wk_st;
        logic                       wake_flag;
        uart_awb_pkg::tx_state_e    tx_st;
        logic [3:0]                 tx_bit;
        logic [8:0]                 tx_sh;
        logic                       tx_brk;
        logic [8:0]                 txbuf;
        logic                       txbuf_full;
        logic                       txd;
    } state_s;

    state_s s_q;
    state_s s_d;
    uart_awb_pkg::bus_req_s req;

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    function automatic logic hit(input uart_awb_pkg::bus_req_s r, input logic [2:0] a);
        hit = r.addr == a;
    endfunction : hit

    logic       baud_tick;
    logic       rx_fall;
    logic       rx_rise;
    logic       nine;
    logic       take_rx;
    logic       transmit_enable;
    logic [3:0] tx_last;
    logic [8:0] rx_word;

    always_comb begin
        s_d = s_q;
        nine = s_q.rcsta[`RC_RX9_BIT];
        transmit_enable = s_q.txsta[`TX_TRANSMIT_ENABLE_BIT];
        take_rx = 1'b0;
        rx_word = 9'h000;
        // ------------------------------------------------------------
        // Pin synchroniser: a change counts when stages two and three agree
        // ------------------------------------------------------------
        s_d.rx_sync = {s_q.rx_sync[1:0], receive_line};
        if (s_q.rx_sync[2] == s_q.rx_sync[1]) begin
            s_d.rx_line = s_q.rx_sync[2];
        end
        rx_fall = s_q.rx_line & ~s_d.rx_line;
        rx_rise = ~s_q.rx_line & s_d.rx_line;

        // ------------------------------------------------------------
        // Oversampling tick, x16 of bit rate
        // ------------------------------------------------------------
        baud_tick = 1'b0;
        // New divisor only takes hold once the running count is used up
        if (s_q.brg_cnt == 16'h0000) begin
            s_d.brg_cnt = {s_q.div_hi, s_q.div_lo};
            baud_tick = 1'b1;
        end else begin
            s_d.brg_cnt = s_q.brg_cnt - 16'h0001;
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (req.wr) begin
            case (req.addr)
                `OFS_RX_STAT_CTRL: begin
                    s_d.rcsta[7:3] = req.wdata[7:3];
                    if (!req.wdata[`RC_CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
                        s_d.rcsta[`RC_OVERRUN_ERROR_BIT] = 1'b0;
                        s_d.ferr0 = 1'b0;
                        s_d.ferr1 = 1'b0;
                    end
                end
                `OFS_TX_STAT_CTRL: begin
                    s_d.txsta[6:5] = req.wdata[6:5];
                    s_d.txsta[`TX_SEND_BREAK_REQUEST_BIT] = req.wdata[`TX_SEND_BREAK_REQUEST_BIT];
                    s_d.txsta[`TX_TX9D_BIT] = req.wdata[`TX_TX9D_BIT];
                end
                `OFS_BAUD_CTRL: begin
                    s_d.wake_en = req.wdata[`BC_WAKE_BIT];
                    s_d.wk_st = req.wdata[`BC_WAKE_BIT] ? uart_awb_pkg::WK_ARMED
                                                        : uart_awb_pkg::WK_OFF;
                end
                `OFS_DIV_HIGH: s_d.div_hi = req.wdata;
                `OFS_DIV_LOW:  s_d.div_lo = req.wdata;
                `OFS_TX_DATA: begin
                    s_d.txbuf = {s_q.txsta[`TX_TX9D_BIT], req.wdata};
                    s_d.txbuf_full = 1'b1;
                end
                `OFS_IRQ_CTRL: s_d.irqc = req.wdata[2:0];
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Receive data read pops FIFO and ends wake condition
        // ------------------------------------------------------------
        if (req.rd && hit(req, `OFS_RX_DATA)) begin
            s_d.wake_flag = 1'b0;
            if (s_q.fcnt != 2'h0) begin
                s_d.fifo0 = s_q.fifo1;
                s_d.ferr0 = s_q.ferr1;
                s_d.fcnt = s_q.fcnt - 2'h1;
            end
        end

        // ------------------------------------------------------------
        // Wake on edge: runs on synchronised line, no baud ticks needed
        // ------------------------------------------------------------
        case (s_q.wk_st)
            uart_awb_pkg::WK_ARMED: begin
                if (rx_fall) begin
                    s_d.wake_flag = 1'b1;
                    s_d.wk_st = uart_awb_pkg::WK_LOW;
                end
            end
            uart_awb_pkg::WK_LOW: begin
                if (rx_rise) begin
                    s_d.wake_en = 1'b0;
                    s_d.wk_st = uart_awb_pkg::WK_OFF;
                end
            end
            default: ;
        endcase

        // ------------------------------------------------------------
        // Receiver; held idle while wake is armed
        // ------------------------------------------------------------
        if (s_q.wake_en || !s_q.rcsta[`RC_SERIAL_PORT_ENABLE_BIT] || !s_q.rcsta[`RC_CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
            s_d.rx_st = uart_awb_pkg::RX_IDLE;
        end else begin
            case (s_q.rx_st)
                uart_awb_pkg::RX_IDLE: begin
                    if (rx_fall) begin
                        s_d.rx_st = uart_awb_pkg::RX_START;
                        s_d.rx_ovs = 4'h0;
                    end
                end
                uart_awb_pkg::RX_START: begin
                    if (baud_tick) begin
                        s_d.rx_ovs = s_q.rx_ovs + 4'h1;
                        if (s_q.rx_ovs == `OVS_MID) begin
                            if (s_q.rx_line) begin
                                s_d.rx_st = uart_awb_pkg::RX_IDLE;
                            end else begin
                                s_d.rx_ovs = 4'h0;
                                s_d.rx_bit = 4'h0;
                                s_d.rx_st = uart_awb_pkg::RX_DATA;
                            end
                        end
                    end
                end
                uart_awb_pkg::RX_DATA: begin
                    if (baud_tick) begin
                        s_d.rx_ovs = s_q.rx_ovs + 4'h1;
                        if (s_q.rx_ovs == `OVS_LAST) begin
                            // LSB first, shift in from top
                            s_d.rx_sh = {s_q.rx_line, s_q.rx_sh[8:1]};
                            s_d.rx_bit = s_q.rx_bit + 4'h1;
                            if (s_q.rx_bit == (nine ? 4'h8 : 4'h7)) begin
                                s_d.rx_st = uart_awb_pkg::RX_STOP;
                            end
                        end
                    end
                end
                uart_awb_pkg::RX_STOP: begin
                    if (baud_tick) begin
                        s_d.rx_ovs = s_q.rx_ovs + 4'h1;
                        if (s_q.rx_ovs == `OVS_LAST) begin
                            s_d.rx_st = uart_awb_pkg::RX_IDLE;
                            take_rx = 1'b1;
                        end
                    end
                end
                default: s_d.rx_st = uart_awb_pkg::RX_IDLE;
            endcase
        end

        if (take_rx) begin
            rx_word = nine ? s_q.rx_sh : {1'b0, s_q.rx_sh[8:1]};
            // Address filter drops data characters
            if (!(nine && s_q.rcsta[`RC_ADDRESS_DETECT_ENABLE_BIT] && !rx_word[8])) begin
                if (s_d.fcnt == 2'(`RX_FIFO_DEPTH)) begin
                    s_d.rcsta[`RC_OVERRUN_ERROR_BIT] = 1'b1;
                end else if (s_d.fcnt == 2'h0) begin
                    s_d.fifo0 = rx_word;
                    s_d.ferr0 = ~s_q.rx_line;
                    s_d.fcnt = 2'h1;
                end else begin
                    s_d.fifo1 = rx_word;
                    s_d.ferr1 = ~s_q.rx_line;
                    s_d.fcnt = 2'h2;
                end
            end
        end
        s_d.rcsta[`RC_FRAMING_ERROR_BIT] = s_d.ferr0;
        s_d.rcsta[`RC_RECEIVED_NINTH_BIT_BIT] = s_d.fifo0[8];

        // ------------------------------------------------------------
        // Transmitter; break and data share the shift path
        // ------------------------------------------------------------
        tx_last = s_q.tx_brk ? (`BREAK_ZEROS - 4'h1)
                             : (s_q.txsta[`TX_TX9_BIT] ? 4'h8 : 4'h7);
        case (s_q.tx_st)
            uart_awb_pkg::TX_IDLE: begin
                s_d.txd = 1'b1;
                if (transmit_enable && s_q.txbuf_full) begin
                    s_d.tx_brk = s_q.txsta[`TX_SEND_BREAK_REQUEST_BIT];
                    // Break drops the written value
                    s_d.tx_sh = s_q.txsta[`TX_SEND_BREAK_REQUEST_BIT] ? 9'h000 : s_q.txbuf;
                    s_d.txbuf_full = req.wr && hit(req, `OFS_TX_DATA);
                    s_d.tx_ovs = 4'h0;
                    s_d.tx_st = uart_awb_pkg::TX_START;
                end
            end
            uart_awb_pkg::TX_START: begin
                s_d.txd = 1'b0;
                if (baud_tick) begin
                    s_d.tx_ovs = s_q.tx_ovs + 4'h1;
                    if (s_q.tx_ovs == `OVS_LAST) begin
                        s_d.tx_bit = 4'h0;
                        s_d.tx_st = uart_awb_pkg::TX_DATA;
                    end
                end
            end
            uart_awb_pkg::TX_DATA: begin
                s_d.txd = s_q.tx_brk ? 1'b0 : s_q.tx_sh[0];
                if (baud_tick) begin
                    s_d.tx_ovs = s_q.tx_ovs + 4'h1;
                    if (s_q.tx_ovs == `OVS_LAST) begin
                        s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
                        s_d.tx_bit = s_q.tx_bit + 4'h1;
                        if (s_q.tx_bit == tx_last) begin
                            s_d.tx_st = uart_awb_pkg::TX_STOP;
                        end
                    end
                end
            end
            uart_awb_pkg::TX_STOP: begin
                s_d.txd = 1'b1;
                if (baud_tick) begin
                    s_d.tx_ovs = s_q.tx_ovs + 4'h1;
                    if (s_q.tx_ovs == `OVS_LAST) begin
                        if (s_q.tx_brk) begin
                            s_d.txsta[`TX_SEND_BREAK_REQUEST_BIT] = 1'b0;
                        end
                        s_d.tx_brk = 1'b0;
                        s_d.tx_st = uart_awb_pkg::TX_IDLE;
                    end
                end
            end
            default: s_d.tx_st = uart_awb_pkg::TX_IDLE;
        endcase
        if (!transmit_enable) begin
            s_d.tx_st = uart_awb_pkg::TX_IDLE;
            s_d.txd = 1'b1;
        end
        s_d.txsta[`TX_SHIFT_REG_EMPTY_BIT] = s_d.tx_st == uart_awb_pkg::TX_IDLE;

        // ------------------------------------------------------------
        // Read data, registered one cycle after strobe
        // ------------------------------------------------------------
        s_d.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `OFS_RX_STAT_CTRL: s_d.rdata = s_q.rcsta;
                `OFS_RX_DATA:      s_d.rdata = s_q.fifo0[7:0];
                `OFS_TX_STAT_CTRL: s_d.rdata = s_q.txsta;
                `OFS_BAUD_CTRL: begin
                    s_d.rdata[`BC_IDLE_BIT] = s_q.rx_st == uart_awb_pkg::RX_IDLE;
                    s_d.rdata[`BC_WAKE_BIT] = s_q.wake_en;
                end
                `OFS_DIV_HIGH:     s_d.rdata = s_q.div_hi;
                `OFS_DIV_LOW:      s_d.rdata = s_q.div_lo;
                `OFS_IRQ_CTRL: begin
                    s_d.rdata[2:0] = s_q.irqc;
                    s_d.rdata[`IC_TXIF_BIT] = transmit_enable & ~s_q.txbuf_full;
                    s_d.rdata[`IC_RCIF_BIT] = (s_q.fcnt != 2'h0) | s_q.wake_flag;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.rx_sync <= 3'h7;
            s_q.rx_line <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.brg_cnt <= `RST_DIV;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out = s_q.rdata;
    assign transmit_out = s_q.txd;
    // Flag gated by both enables
    assign irq_out = ((s_q.fcnt != 2'h0) | s_q.wake_flag)
                   & s_q.irqc[`IC_RCIE_BIT] & s_q.irqc[`IC_GIE_BIT];

endmodule : uart_addr_wake_break

/* src/uart_awb_cfg.svh */
// Offsets, field positions, reset values and timing counts of the serial block.
// Assumes inclusion by bare name from design files.
`ifndef UART_AWB_CFG_SVH
`define UART_AWB_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_RX_STAT_CTRL  3'h0
`define OFS_RX_DATA       3'h1
`define OFS_TX_STAT_CTRL  3'h2
`define OFS_BAUD_CTRL     3'h3
`define OFS_DIV_HIGH      3'h4
`define OFS_DIV_LOW       3'h5
`define OFS_TX_DATA       3'h6
`define OFS_IRQ_CTRL      3'h7

// ----------------------------------------------------------------
// Receive status/control fields
// ----------------------------------------------------------------
`define RC_SERIAL_PORT_ENABLE_BIT   7
`define RC_RX9_BIT    6
`define RC_CONTINUOUS_RECEIVE_ENABLE_BIT   4
`define RC_ADDRESS_DETECT_ENABLE_BIT  3
`define RC_FRAMING_ERROR_BIT   2
`define RC_OVERRUN_ERROR_BIT   1
`define RC_RECEIVED_NINTH_BIT_BIT   0

// ----------------------------------------------------------------
// Transmit status/control fields
// ----------------------------------------------------------------
`define TX_TX9_BIT    6
`define TX_TRANSMIT_ENABLE_BIT   5
`define TX_SEND_BREAK_REQUEST_BIT  3
`define TX_SHIFT_REG_EMPTY_BIT   1
`define TX_TX9D_BIT   0

// ----------------------------------------------------------------
// Baud control and irq control fields
// ----------------------------------------------------------------
`define BC_IDLE_BIT   6
`define BC_WAKE_BIT   1
`define IC_RCIE_BIT   0
`define IC_GIE_BIT    1
`define IC_RCIP_BIT   2
`define IC_TXIF_BIT   4
`define IC_RCIF_BIT   5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RST_DIV       16'h0000
`define BREAK_ZEROS   4'hc
`define OVS_LAST      4'hf
`define OVS_MID       4'h7
`define RX_FIFO_DEPTH 2

`endif

/* src/uart_awb_pkg.sv */
// Types of the serial block: register bus carrier and receive, transmit and wake states.
// Assumes the cfg header is included by the design file.
package uart_awb_pkg;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_e;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b10,
        TX_STOP  = 2'b11
    } tx_state_e;

    typedef enum logic [1:0] {
        WK_OFF   = 2'b00,
        WK_ARMED = 2'b01,
        WK_LOW   = 2'b10
    } wake_state_e;

endpackage : uart_awb_pkg

/* tb/remote_node.sv */
// Remote serial node: sends characters and samples the block's output.
// Assumes the block runs at 16 clocks per bit.
`timescale 1ns/1ns
module remote_node #(
    parameter int BIT_CYC = 16   // Clocks per serial bit
) (
    input  wire logic clk_in,    // System clock
    input  wire logic tx_in,     // Block's serial output
    output logic      line_out   // Block's serial input
);
    initial line_out = 1'b1;
    // Start, data LSB first, stop; line rests high after it
    task automatic send_word(input logic [8:0] w, input int nbits);
        @(posedge clk_in);
        for (int i = 0; i < nbits + 2; i++) begin
            line_out <= (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : w[i-1];
            repeat (BIT_CYC) @(posedge clk_in);
        end
    endtask : send_word
    // Samples mid-bit; returns in the last bit so a following frame is not missed
    task automatic catch_frame(input int n, output logic [13:0] v);
        int t;
        v = 'x;
        t = 0;
        while (tx_in !== 1'b0 && t < 4000) begin
            @(posedge clk_in);
            t++;
        end
        if (t < 4000) begin
            repeat (BIT_CYC / 2) @(posedge clk_in);
            v[0] = tx_in;
            for (int i = 1; i < n; i++) begin
                repeat (BIT_CYC) @(posedge clk_in);
                v[i] = tx_in;
            end
        end
    endtask : catch_frame
endmodule : remote_node

/* tb/tb_uart_addr_wake_break.sv */
// Self-checking bench of the serial block with a remote node.
// Assumes divisor zero, so one bit lasts 16 clocks.
`timescale 1ns/1ns
`include "uart_awb_cfg.svh"
module tb_uart_addr_wake_break;
    logic        clk_in;
    logic        rst_in;
    logic [2:0]  addr_in;
    logic [7:0]  wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic [7:0]  rdata_out;
    logic        receive_line;
    logic        transmit_out;
    logic        irq_out;
    logic [7:0]  d;
    logic [13:0] fr;
    int          n_fail;
    int          total_checks;
    logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
    uart_addr_wake_break dut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .receive_line, .transmit_out, .irq_out);
    remote_node #(.BIT_CYC(16)) node (.clk_in, .tx_in(transmit_out), .line_out(receive_line));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 v = rdata_out;
    endtask : bus_rd
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] v;
        bus_rd(a, v);
        chk({6'h00, v & m}, {6'h00, e});
    endtask : rd_chk
    // Bounded wait; a lost interrupt ends the run at once
    task automatic wait_irq(input logic lvl);
        int t;
        t = 0;
        while (irq_out !== lvl && t < 3000) begin
            @(posedge clk_in);
            t++;
        end
        chk({13'h0000, irq_out}, {13'h0000, lvl});
        if (t >= 3000) begin
            give_verdict();
        end
    endtask : wait_irq
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        wr_in = 1'b0;
        rd_in = 1'b0;
        n_fail = 0;
        total_checks = 0;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(3'(i), rst_val[i], 8'hff);
        end
        bus_wr(`OFS_DIV_LOW, 8'h5a);
        rd_chk(`OFS_DIV_LOW, 8'h5a, 8'hff);
        bus_wr(`OFS_DIV_LOW, 8'h00);
        // Let the count loaded from the old divisor run out before any frame
        repeat (96) @(posedge clk_in);
        bus_wr(`OFS_IRQ_CTRL, 8'h03);
        bus_wr(`OFS_RX_STAT_CTRL, 8'hd8);
        node.send_word(9'h011, 9);
        chk({13'h0000, irq_out}, 14'h0000);
        node.send_word(9'h1a5, 9);
        wait_irq(1'b1);
        rd_chk(`OFS_RX_STAT_CTRL, 8'hd9, 8'hff);
        rd_chk(`OFS_RX_DATA, 8'ha5, 8'hff);
        wait_irq(1'b0);
        bus_wr(`OFS_RX_STAT_CTRL, 8'hd0);
        node.send_word(9'h03c, 9);
        wait_irq(1'b1);
        rd_chk(`OFS_RX_DATA, 8'h3c, 8'hff);
        bus_wr(`OFS_RX_STAT_CTRL, 8'h90);
        for (int i = 1; i < 4; i++) begin
            node.send_word(9'(i), 8);
        end
        rd_chk(`OFS_RX_STAT_CTRL, 8'h92, 8'hff);
        rd_chk(`OFS_RX_DATA, 8'h01, 8'hff);
        rd_chk(`OFS_RX_DATA, 8'h02, 8'hff);
        bus_wr(`OFS_RX_STAT_CTRL, 8'h80);
        rd_chk(`OFS_RX_STAT_CTRL, 8'h80, 8'hff);
        bus_wr(`OFS_RX_STAT_CTRL, 8'h90);
        rd_chk(`OFS_BAUD_CTRL, 8'h40, 8'h40);
        bus_wr(`OFS_BAUD_CTRL, 8'h02);
        rd_chk(`OFS_BAUD_CTRL, 8'h02, 8'h02);
        fork
            node.send_word(9'h000, 8);
            begin
                wait_irq(1'b1);
                rd_chk(`OFS_BAUD_CTRL, 8'h42, 8'h42);
            end
        join
        rd_chk(`OFS_BAUD_CTRL, 8'h00, 8'h02);
        bus_rd(`OFS_RX_DATA, d);
        wait_irq(1'b0);
        node.send_word(9'h05a, 8);
        wait_irq(1'b1);
        rd_chk(`OFS_RX_DATA, 8'h5a, 8'hff);
        bus_wr(`OFS_TX_STAT_CTRL, 8'h28);
        rd_chk(`OFS_IRQ_CTRL, 8'h10, 8'h10);
        fork
            node.catch_frame(14, fr);
            begin
                bus_wr(`OFS_TX_DATA, 8'hff);
                rd_chk(`OFS_IRQ_CTRL, 8'h10, 8'h10);
                bus_wr(`OFS_TX_DATA, 8'h55);
                rd_chk(`OFS_TX_STAT_CTRL, 8'h08, 8'h0a);
            end
        join
        chk(fr, 14'h2000);
        node.catch_frame(10, fr);
        chk({4'h0, fr[9:0]}, 14'h02aa);
        repeat (16) @(posedge clk_in);
        rd_chk(`OFS_TX_STAT_CTRL, 8'h02, 8'h0a);
        give_verdict();
    end
endmodule : tb_uart_addr_wake_break

/* tb/uart_awb_monitor.sv */
// Port-level checker of the serial block, attached by bind.
// Assumes one clock domain and a divisor of zero: 16 clocks per bit.
`timescale 1ns/1ns
`include "uart_awb_cfg.svh"
module uart_awb_monitor #(
    parameter int BIT_CYC = 16          // Clocks per serial bit
) (
    input  wire logic       clk_in,       // System clock
    input  wire logic       rst_in,       // Sync reset
    input  wire logic [2:0] addr_in,      // Register index
    input  wire logic [7:0] wdata_in,     // Write data
    input  wire logic       wr_in,        // Write strobe
    input  wire logic       rd_in,        // Read strobe
    input  wire logic [7:0] rdata_out,    // Read data
    input  wire logic       receive_line, // Serial in
    input  wire logic       transmit_out, // Serial out
    input  wire logic       irq_out       // Interrupt request
);
    // ----------------------------------------------------------------
    // Shadow state
    // ----------------------------------------------------------------
    logic [9:0] low_q;
    logic [2:0] hi_q;
    logic [1:0] ie_q;
    logic       transmit_enable_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            low_q  <= 10'h000;
            hi_q   <= 3'h0;
            ie_q   <= 2'h0;
            transmit_enable_q <= 1'b0;
        end else begin
            low_q <= transmit_out ? 10'h000 : low_q + 10'h001;
            // Saturates so a long idle line stays recognisable
            hi_q  <= !receive_line ? 3'h0 : hi_q + {2'h0, hi_q != 3'h7};
            if (wr_in && addr_in == `OFS_IRQ_CTRL) begin
                ie_q <= {wdata_in[`IC_GIE_BIT], wdata_in[`IC_RCIE_BIT]};
            end
            if (wr_in && addr_in == `OFS_TX_STAT_CTRL) begin
                transmit_enable_q <= wdata_in[`TX_TRANSMIT_ENABLE_BIT];
            end
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_idle; $fell(rst_in) |-> transmit_out; endproperty
    a_idle: assert property (p_idle) else $error("line not idle after reset");
    property p_whole; $rose(transmit_out) |-> low_q % BIT_CYC == 0 && low_q != 0; endproperty
    a_whole: assert property (p_whole) else $error("low run not whole bits");
    property p_brk; $rose(transmit_out) |-> low_q <= 13 * BIT_CYC; endproperty
    a_brk: assert property (p_brk) else $error("low run over break length");
    property p_irq; ie_q != 2'h3 |-> !irq_out; endproperty
    a_irq: assert property (p_irq) else $error("irq without both enables");
    property p_shift_reg_empty; rd_in && addr_in == `OFS_TX_STAT_CTRL && !transmit_out
        |=> !rdata_out[`TX_SHIFT_REG_EMPTY_BIT]; endproperty
    a_shift_reg_empty: assert property (p_shift_reg_empty) else $error("shift empty while sending");
    property p_txif; rd_in && addr_in == `OFS_IRQ_CTRL && !transmit_enable_q
        |=> !rdata_out[`IC_TXIF_BIT]; endproperty
    a_txif: assert property (p_txif) else $error("buffer flag without enable");
    property p_txoff; !transmit_enable_q [*3] |-> transmit_out; endproperty
    a_txoff: assert property (p_txoff) else $error("sending while disabled");
    property p_wake; (wr_in && addr_in == `OFS_BAUD_CTRL && wdata_in[`BC_WAKE_BIT] && hi_q == 3'h7)
        ##2 (rd_in && addr_in == `OFS_BAUD_CTRL && receive_line)
        |=> rdata_out[`BC_WAKE_BIT]; endproperty
    a_wake: assert property (p_wake) else $error("wake enable not held");
endmodule : uart_awb_monitor
bind uart_addr_wake_break uart_awb_monitor #(.BIT_CYC(16)) mon (
    .clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .receive_line, .transmit_out, .irq_out
);
